// ### rtl/srt_pkg.sv
// Package for the split reload timer: register map, fields, carriers
package srt_pkg;
  // Byte addresses of the registers
  localparam logic [7:0] SRT_ADDR_CTRL = 8'hC8;
  localparam logic [7:0] SRT_ADDR_CNTL = 8'hCC;
  localparam logic [7:0] SRT_ADDR_CNTH = 8'hD0;
  localparam logic [7:0] SRT_ADDR_RLL = 8'hD4;
  localparam logic [7:0] SRT_ADDR_RLH = 8'hD8;
  localparam logic [7:0] SRT_ADDR_CLKC = 8'hDC;
  localparam logic [7:0] SRT_ADDR_IRQST = 8'hE0;
  localparam logic [7:0] SRT_ADDR_IRQCLR = 8'hE4;
  localparam logic [7:0] SRT_ADDR_IRQEN = 8'hE8;
  // Control register field positions
  localparam int SRT_CTL_HFLAG = 7;
  localparam int SRT_CTL_LFLAG = 6;
  localparam int SRT_CTL_LIRQEN = 5;
  localparam int SRT_CTL_SPLIT = 3;
  localparam int SRT_CTL_RUN = 2;
  localparam int SRT_CTL_XCLK = 0;
  // Clock control register field positions
  localparam int SRT_CLK_HSEL = 6;
  localparam int SRT_CLK_LSEL = 5;
  // Interrupt status bit positions (same layout for clear and enable)
  localparam int SRT_IRQ_HIGH = 0;
  localparam int SRT_IRQ_LOW = 1;
  // Reset values
  localparam logic [7:0] SRT_RST_BYTE = 8'h00;
  localparam logic [15:0] SRT_RST_WORD = 16'h0000;
  // Divider counts
  localparam int SRT_DIV_SYS = 12;
  localparam int SRT_DIV_EXT = 8;
  localparam logic [15:0] SRT_CNT_MAX = 16'hFFFF;
  localparam logic [7:0] SRT_BYTE_MAX = 8'hFF;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } srt_apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } srt_apb_rsp_t;

  // Control register contents
  typedef struct packed {
    logic hflag;
    logic lflag;
    logic lirq_en;
    logic split;
    logic run;
    logic xclk;
  } srt_ctl_t;
endpackage : srt_pkg

// ### rtl/srt_timer.sv
// Split reload timer with APB register access and one interrupt output
// Functional notes
// [RL1] 16-bit rollover reloads and sets high flag
// [RL2] Ticks: system clock, divide 12, external divide 8
// [RL3] External tick resynchronised to system clock
// [RL4] Timer interrupt on every high overflow
// [RL5] Low overflow interrupts when low enable set
// [RL6] Split mode: two 8-bit reload counters
// [RL7] Run gates all, or only high byte
// [RL8] Per-byte select: system clock or external choice
// [RL9] Byte rollovers set their own flags
// [RL10] Flags cleared only by software writes
// [RL11] Software keeps low enable clear in 16-bit
// [RL12] Control bits 4 and 1 read zero
// [RL13] Control register field layout at 0xC8
// [RL14] Handler checks both flags for source
// [RL15] One external select shared by both bytes
// [RL16] High count register shows high byte
// [RL17] One count per single-cycle tick enable
// [RL18] All registers reset to zero
//
// Local design decision: the APB interface to the registers.
module srt_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire srt_pkg::srt_apb_req_t apb_req,
  output srt_pkg::srt_apb_rsp_t apb_rsp,
  // External oscillator source
  input wire logic ext_clk_in,
  // Interrupt
  output logic irq
);
  import srt_pkg::*;

  // Whole module state
  typedef struct packed {
    srt_ctl_t ctl;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] rl_lo;
    logic [7:0] rl_hi;
    logic hsel;
    logic lsel;
    logic [1:0] ist;
    logic [1:0] ien;
    logic [3:0] div12;
    logic [2:0] sync;
    logic [2:0] div8;
    logic tick8;
    srt_apb_rsp_t rsp;
    logic irq;
  } srt_state_t;

  srt_state_t s_q;
  srt_state_t s_d;
  // Helper ticks, also watched by the assertions
  logic tick12;
  logic tick_lo;
  logic tick_hi;
  logic ovf_lo;
  logic ovf_hi;
  logic wr;

  // Next state: dividers, counters, flags and register access
  always_comb
  begin
    logic [31:0] rd;
    logic [15:0] cnt16;
    logic errv;
    logic [1:0] clr;
    rd = 32'h0000_0000;
    cnt16 = {s_q.cnt_hi, s_q.cnt_lo};
    errv = 1'b0;
    clr = 2'b00;
    s_d = s_q;
    ovf_lo = 1'b0;
    ovf_hi = 1'b0;

    // System clock divided by 12
    tick12 = (s_q.div12 == 4'(SRT_DIV_SYS - 1)); // see [RL2]
    s_d.div12 = tick12 ? 4'h0 : s_q.div12 + 4'h1;

    // Two-flop resync, then edge count divided by 8; one pulse per eight edges
    s_d.sync = {s_q.sync[1:0], ext_clk_in}; // see [RL3]
    s_d.tick8 = 1'b0;
    if (s_q.sync[1] && !s_q.sync[2])
    begin
      s_d.div8 = s_q.div8 + 3'h1;
      s_d.tick8 = (s_q.div8 == 3'(SRT_DIV_EXT - 1)); // see [RL2]
    end

    // Per-byte tick choice; in 16-bit mode the low select drives the timer
    tick_lo = s_q.lsel ? 1'b1 : (s_q.ctl.xclk ? s_q.tick8 : tick12); // see [RL8] [RL15]
    tick_hi = s_q.hsel ? 1'b1 : (s_q.ctl.xclk ? s_q.tick8 : tick12); // see [RL8] [RL15]

    // Counting
    if (!s_q.ctl.split)
    begin
      // One 16-bit counter, gated by run
      if (s_q.ctl.run && tick_lo) // see [RL7] [RL17]
      begin
        ovf_lo = (s_q.cnt_lo == SRT_BYTE_MAX); // see [RL9]
        if (cnt16 == SRT_CNT_MAX)
        begin
          // Reload whole word on full overflow
          ovf_hi = 1'b1; // see [RL1]
          s_d.cnt_lo = s_q.rl_lo;
          s_d.cnt_hi = s_q.rl_hi;
        end
        else
        begin
          {s_d.cnt_hi, s_d.cnt_lo} = cnt16 + 16'h0001;
        end
      end
    end
    else
    begin
      // Low byte always runs in split mode
      if (tick_lo) // see [RL6] [RL7]
      begin
        ovf_lo = (s_q.cnt_lo == SRT_BYTE_MAX); // see [RL9]
        s_d.cnt_lo = ovf_lo ? s_q.rl_lo : s_q.cnt_lo + 8'h01;
      end
      // High byte only while run is set
      if (s_q.ctl.run && tick_hi) // see [RL6] [RL7]
      begin
        ovf_hi = (s_q.cnt_hi == SRT_BYTE_MAX); // see [RL9]
        s_d.cnt_hi = ovf_hi ? s_q.rl_hi : s_q.cnt_hi + 8'h01;
      end
    end

    // APB: answer in the first access cycle, write on the ready edge
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite && s_q.rsp.pready;
    if (wr)
    begin
      unique case (apb_req.paddr)
        SRT_ADDR_CTRL:
        begin
          // Bits 4 and 1 have no storage, so writes to them vanish
          s_d.ctl.hflag = apb_req.pwdata[SRT_CTL_HFLAG]; // see [RL10] [RL13]
          s_d.ctl.lflag = apb_req.pwdata[SRT_CTL_LFLAG];
          s_d.ctl.lirq_en = apb_req.pwdata[SRT_CTL_LIRQEN];
          s_d.ctl.split = apb_req.pwdata[SRT_CTL_SPLIT];
          s_d.ctl.run = apb_req.pwdata[SRT_CTL_RUN];
          s_d.ctl.xclk = apb_req.pwdata[SRT_CTL_XCLK];
        end
        // A software write to a count byte wins over a tick
        SRT_ADDR_CNTL: s_d.cnt_lo = apb_req.pwdata[7:0];
        SRT_ADDR_CNTH: s_d.cnt_hi = apb_req.pwdata[7:0];
        SRT_ADDR_RLL: s_d.rl_lo = apb_req.pwdata[7:0];
        SRT_ADDR_RLH: s_d.rl_hi = apb_req.pwdata[7:0];
        SRT_ADDR_CLKC:
        begin
          s_d.hsel = apb_req.pwdata[SRT_CLK_HSEL];
          s_d.lsel = apb_req.pwdata[SRT_CLK_LSEL];
        end
        SRT_ADDR_IRQCLR: clr = apb_req.pwdata[1:0];
        SRT_ADDR_IRQEN: s_d.ien = apb_req.pwdata[1:0];
        default: ;
      endcase
    end

    // Hardware sets win over any clear in the same cycle
    s_d.ist = (s_q.ist & ~clr) | {ovf_lo, ovf_hi};
    if (ovf_hi)
    begin
      s_d.ctl.hflag = 1'b1; // see [RL1] [RL9]
    end
    if (ovf_lo)
    begin
      s_d.ctl.lflag = 1'b1; // see [RL9]
    end

    // Read data decode during the setup cycle
    unique case (apb_req.paddr)
      SRT_ADDR_CTRL: rd[7:0] = {s_q.ctl.hflag, s_q.ctl.lflag, s_q.ctl.lirq_en, 1'b0,
        s_q.ctl.split, s_q.ctl.run, 1'b0, s_q.ctl.xclk}; // see [RL12] [RL13]
      SRT_ADDR_CNTL: rd[7:0] = s_q.cnt_lo;
      SRT_ADDR_CNTH: rd[7:0] = s_q.cnt_hi; // see [RL16]
      SRT_ADDR_RLL: rd[7:0] = s_q.rl_lo;
      SRT_ADDR_RLH: rd[7:0] = s_q.rl_hi;
      SRT_ADDR_CLKC: rd[7:0] = {1'b0, s_q.hsel, s_q.lsel, 5'h00};
      SRT_ADDR_IRQST: rd[1:0] = s_q.ist;
      SRT_ADDR_IRQCLR: rd = 32'h0000_0000;
      SRT_ADDR_IRQEN: rd[1:0] = s_q.ien;
      default: errv = 1'b1;
    endcase

    // Response registers
    if (apb_req.psel && !apb_req.penable)
    begin
      s_d.rsp.pready = 1'b1;
      s_d.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rd;
      s_d.rsp.pslverr = errv;
    end
    else
    begin
      s_d.rsp.pready = 1'b0;
      s_d.rsp.pslverr = 1'b0;
    end

    // Interrupt: enable bit 0 is the timer enable, bit 1 adds low events
    s_d.irq = s_d.ien[SRT_IRQ_HIGH] && (s_d.ist[SRT_IRQ_HIGH] // see [RL4]
      || (s_d.ist[SRT_IRQ_LOW] && s_d.ien[SRT_IRQ_LOW] && s_d.ctl.lirq_en)); // see [RL5]
  end

  // State register; everything clears on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0; // see [RL18]
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign apb_rsp = s_q.rsp;
  assign irq = s_q.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Full 16-bit overflow reloads the word
  sequence wrap16_s;
    !s_q.ctl.split && s_q.ctl.run && tick_lo && {s_q.cnt_hi, s_q.cnt_lo} == SRT_CNT_MAX && !wr;
  endsequence
  reload_16bit_a: assert property (wrap16_s |=> s_q.ctl.hflag // see [RL1]
    && {s_q.cnt_hi, s_q.cnt_lo} == {$past(s_q.rl_hi), $past(s_q.rl_lo)})
    else $error("16-bit overflow did not reload");

  div12_period_a: assert property (tick12 |-> ##12 tick12) // see [RL2]
    else $error("divide by 12 period wrong");

  ext_tick_gap_a: assert property (s_q.tick8 |=> !s_q.tick8) // see [RL3]
    else $error("external tick too fast");

  high_irq_a: assert property (s_q.ist[SRT_IRQ_HIGH] && s_q.ien[SRT_IRQ_HIGH] |-> irq) // see [RL4]
    else $error("high overflow interrupt missing");

  low_irq_a: assert property (s_q.ist[SRT_IRQ_LOW] && s_q.ien == 2'b11 // see [RL5]
    && s_q.ctl.lirq_en |-> irq)
    else $error("low overflow interrupt missing");

  split_low_reload_a: assert property (s_q.ctl.split && tick_lo // see [RL6]
    && s_q.cnt_lo == SRT_BYTE_MAX && !wr |=> s_q.cnt_lo == $past(s_q.rl_lo) && s_q.ctl.lflag)
    else $error("split low byte did not reload");

  split_high_hold_a: assert property (s_q.ctl.split && !s_q.ctl.run && !wr // see [RL7]
    |=> $stable(s_q.cnt_hi))
    else $error("high byte moved while stopped");

  flag_sticky_a: assert property (s_q.ctl.hflag && !wr |=> s_q.ctl.hflag) // see [RL10]
    else $error("high flag cleared by hardware");

  ctl_unused_a: assert property (apb_rsp.pready && $past(apb_req.paddr) == SRT_ADDR_CTRL // see [RL12]
    |-> apb_rsp.prdata[4] == 1'b0 && apb_rsp.prdata[1] == 1'b0)
    else $error("unused control bits read as one");

  // Further checks on counting, flags, ticks and the register bus.
  // They sample the flops and helper ticks, so a mismatch points at
  // the next-state logic rather than at the bus timing.

  // Split high byte: a full byte wraps to its own reload value
  // and raises the high flag in the same edge
  sequence split_hi_wrap_s;
    s_q.ctl.split && s_q.ctl.run && tick_hi && s_q.cnt_hi == SRT_BYTE_MAX && !wr;
  endsequence
  split_high_reload_a: assert property (split_hi_wrap_s // see [RL6]
    |=> s_q.cnt_hi == $past(s_q.rl_hi) && s_q.ctl.hflag)
    else $error("split high byte did not reload");

  // Low byte wrap inside the 16-bit count also marks the low flag,
  // which is why software should keep the low interrupt off here
  sequence wide_lo_wrap_s;
    !s_q.ctl.split && s_q.ctl.run && tick_lo && s_q.cnt_lo == SRT_BYTE_MAX && !wr;
  endsequence
  low_flag_wide_a: assert property (wide_lo_wrap_s |=> s_q.ctl.lflag) // see [RL9]
    else $error("low flag missed in 16-bit mode");

  // Ordinary 16-bit step: exactly one count per tick, carry included
  sequence wide_step_s;
    !s_q.ctl.split && s_q.ctl.run && tick_lo
      && {s_q.cnt_hi, s_q.cnt_lo} != SRT_CNT_MAX && !wr;
  endsequence
  wide_increment_a: assert property (wide_step_s // see [RL17]
    |=> {s_q.cnt_hi, s_q.cnt_lo} == 16'($past({s_q.cnt_hi, s_q.cnt_lo}) + 16'h0001))
    else $error("16-bit count did not step by one");

  // Split low byte ignores run and steps once per tick below the top
  split_low_free_a: assert property (s_q.ctl.split && tick_lo // see [RL7]
    && s_q.cnt_lo != SRT_BYTE_MAX && !wr
    |=> s_q.cnt_lo == 8'($past(s_q.cnt_lo) + 8'h01))
    else $error("split low byte did not step");

  // Stopped 16-bit timer holds both bytes
  wide_stop_hold_a: assert property (!s_q.ctl.split && !s_q.ctl.run && !wr // see [RL7]
    |=> $stable(s_q.cnt_lo) && $stable(s_q.cnt_hi))
    else $error("16-bit count moved while stopped");

  // No tick on either byte means no movement at all
  no_tick_hold_a: assert property (!tick_lo && !tick_hi && !wr // see [RL17]
    |=> $stable(s_q.cnt_lo) && $stable(s_q.cnt_hi))
    else $error("count moved without a tick");

  // The low flag is sticky as well; only a control write drops it
  low_flag_sticky_a: assert property (s_q.ctl.lflag && !wr |=> s_q.ctl.lflag) // see [RL10]
    else $error("low flag cleared by hardware");

  // A set byte select forces the system clock, whatever the shared select says
  sys_clock_sel_a: assert property (s_q.lsel && s_q.hsel |-> tick_lo && tick_hi) // see [RL8]
    else $error("system clock select ignored");

  // The external tick only follows a rising edge seen by the second
  // and third sync flops, never the raw pin
  ext_tick_sync_a: assert property (s_q.tick8 // see [RL3]
    |-> $past(s_q.sync[1]) && !$past(s_q.sync[2]))
    else $error("external tick without a synced edge");

  // Divider wraps to zero on the eighth edge, so ticks are eight edges apart
  ext_div_wrap_a: assert property (s_q.tick8 |-> s_q.div8 == 3'h0) // see [RL2]
    else $error("external divider out of step");

  // Interrupt stays low while the timer enable bit is clear
  irq_gate_a: assert property (!s_q.ien[SRT_IRQ_HIGH] |-> !irq) // see [RL4]
    else $error("interrupt without timer enable");

  // An interrupt always has a pending status bit behind it
  irq_source_a: assert property (irq |-> s_q.ist != 2'b00) // see [RL5]
    else $error("interrupt with no pending status");

  // Register bus: every setup cycle is answered in the very next cycle,
  // and the ready pulse lasts one cycle only
  sequence setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  ready_next_a: assert property (setup_s |=> apb_rsp.pready)
    else $error("setup cycle not answered");
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held longer than one cycle");

  // The control register is always mapped, so it never reports an error
  ctl_no_err_a: assert property (apb_rsp.pready // see [RL13]
    && $past(apb_req.paddr) == SRT_ADDR_CTRL |-> !apb_rsp.pslverr)
    else $error("control register access flagged as error");

  // A run bit written over the bus lands on the ready edge
  run_write_a: assert property (wr && apb_req.paddr == SRT_ADDR_CTRL // see [RL13]
    |=> s_q.ctl.run == $past(apb_req.pwdata[SRT_CTL_RUN]))
    else $error("run bit write lost");

  // Split and shared-select writes land together with run
  mode_write_a: assert property (wr && apb_req.paddr == SRT_ADDR_CTRL // see [RL15]
    |=> s_q.ctl.split == $past(apb_req.pwdata[SRT_CTL_SPLIT])
    && s_q.ctl.xclk == $past(apb_req.pwdata[SRT_CTL_XCLK]))
    else $error("mode bits write lost");

  // A byte written to a counter wins over a tick in the same cycle
  cnt_write_a: assert property (wr && apb_req.paddr == SRT_ADDR_CNTL
    |=> s_q.cnt_lo == $past(apb_req.pwdata[7:0]))
    else $error("low count write lost");

  // Status clear takes effect unless an overflow lands in the same cycle
  irq_clear_a: assert property (wr && apb_req.paddr == SRT_ADDR_IRQCLR // see [RL10]
    && apb_req.pwdata[SRT_IRQ_HIGH] && !ovf_hi |=> !s_q.ist[SRT_IRQ_HIGH])
    else $error("high status not cleared");

  // Split high byte stays put while its tick is absent
  split_high_idle_a: assert property (s_q.ctl.split && !tick_hi && !wr // see [RL6]
    |=> $stable(s_q.cnt_hi))
    else $error("split high byte moved without a tick");

  // Reload bytes only change by a bus write
  reload_hold_a: assert property (!wr |=> $stable(s_q.rl_lo) && $stable(s_q.rl_hi)) // see [RL6]
    else $error("reload byte changed without a write");
endmodule // srt_timer

// ### tb/srt_timer_tb_top.sv
// Self-checking bench for the split reload timer
module srt_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import srt_pkg::*;
  // Bench-driven stimulus
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ext_clk_in = 1'b0;
  srt_apb_req_t apb_req = '0;
  // Design outputs
  srt_apb_rsp_t apb_rsp;
  logic irq;
  // Bookkeeping
  int fails = 0;
  int num_checks = 0;
  int seed = 32'h2093;
  logic [31:0] rnd;
  logic [32:0] exp_q[$];
  logic [7:0] reg_a[7] = '{SRT_ADDR_CTRL, SRT_ADDR_CNTL, SRT_ADDR_CNTH,
    SRT_ADDR_RLL, SRT_ADDR_RLH, SRT_ADDR_CLKC, SRT_ADDR_IRQEN};

  srt_timer u_srt_timer (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .ext_clk_in(ext_clk_in),
    .irq(irq)
  );

  // 25 MHz clock
  always #20 pclk = ~pclk;

  // Compare and count
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One APB transfer; called at a rising edge, ends one idle edge later
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 20);
    // Only a missing answer counts as a hang, not one on the last try
    if (apb_rsp.pready !== 1'b1)
    begin
      fails++;
      wrap_up();
    end
    // Idle edge keeps the next setup from landing in the same step
    apb_req <= '0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // Expected {pslverr, prdata} is queued before the read starts
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  // Eight external edges per tick; edges kept in multiples of eight
  task automatic ext_tick();
    repeat (8)
    begin
      ext_clk_in <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_clk_in <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    // Allow for the resynchroniser latency
    repeat (8) @(posedge pclk);
  endtask

  // Read monitor: takes the oldest note at each completed read
  always @(posedge pclk)
    if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(33'h1_FFFF_FFFF, 33'h0_0000_0000);
      else
        chk({apb_rsp.pslverr, apb_rsp.prdata}, exp_q.pop_front());
    end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (reg_a[i]) rd(reg_a[i], 33'h0_0000_0000);
    rd(8'hF0, 33'h1_0000_0000);
    wr(SRT_ADDR_CTRL, 32'hFFFF_FF16);
    rd(SRT_ADDR_CTRL, 33'h0_0000_0004);
    // Frozen timer: external source with the pin idle
    wr(SRT_ADDR_CTRL, 32'h0000_0001);
    for (int i = 1; i < 5; i++)
    begin
      rnd = $random(seed);
      wr(reg_a[i], rnd);
      rd(reg_a[i], {25'h0, rnd[7:0]});
    end
    wr(SRT_ADDR_IRQST, 32'h0000_0003);
    rd(SRT_ADDR_IRQST, 33'h0_0000_0000);
    // Full 16-bit wrap from the external divided tick
    wr(SRT_ADDR_RLL, 32'h0000_0034);
    wr(SRT_ADDR_RLH, 32'h0000_0012);
    wr(SRT_ADDR_CNTL, 32'h0000_00FE);
    wr(SRT_ADDR_CNTH, 32'h0000_00FF);
    wr(SRT_ADDR_CTRL, 32'h0000_0005);
    ext_tick();
    rd(SRT_ADDR_CNTL, 33'h0_0000_00FF);
    rd(SRT_ADDR_CTRL, 33'h0_0000_0005);
    ext_tick();
    rd(SRT_ADDR_CNTL, 33'h0_0000_0034);
    rd(SRT_ADDR_CNTH, 33'h0_0000_0012);
    rd(SRT_ADDR_CTRL, 33'h0_0000_00C5);
    rd(SRT_ADDR_IRQST, 33'h0_0000_0003);
    chk({32'h0, irq}, 33'h0_0000_0000);
    wr(SRT_ADDR_IRQEN, 32'h0000_0001);
    chk({32'h0, irq}, 33'h0_0000_0001);
    // Run off gates the whole 16-bit counter
    wr(SRT_ADDR_CTRL, 32'h0000_0001);
    ext_tick();
    rd(SRT_ADDR_CNTL, 33'h0_0000_0034);
    rd(SRT_ADDR_CTRL, 33'h0_0000_0001);
    wr(SRT_ADDR_IRQCLR, 32'h0000_0003);
    chk({32'h0, irq}, 33'h0_0000_0000);
    // Split mode, run off: only the low byte counts
    wr(SRT_ADDR_IRQEN, 32'h0000_0003);
    wr(SRT_ADDR_CTRL, 32'h0000_0029);
    wr(SRT_ADDR_RLL, 32'h0000_0080);
    wr(SRT_ADDR_RLH, 32'h0000_0040);
    wr(SRT_ADDR_CNTL, 32'h0000_00FF);
    wr(SRT_ADDR_CNTH, 32'h0000_00FF);
    ext_tick();
    rd(SRT_ADDR_CNTL, 33'h0_0000_0080);
    rd(SRT_ADDR_CNTH, 33'h0_0000_00FF);
    rd(SRT_ADDR_CTRL, 33'h0_0000_0069);
    chk({32'h0, irq}, 33'h0_0000_0001);
    wr(SRT_ADDR_IRQCLR, 32'h0000_0003);
    chk({32'h0, irq}, 33'h0_0000_0000);
    // Run on: high byte wraps to its own reload
    wr(SRT_ADDR_CTRL, 32'h0000_002D);
    ext_tick();
    rd(SRT_ADDR_CNTL, 33'h0_0000_0081);
    rd(SRT_ADDR_CNTH, 33'h0_0000_0040);
    rd(SRT_ADDR_CTRL, 33'h0_0000_00AD);
    rd(SRT_ADDR_IRQST, 33'h0_0000_0001);
    // Low byte on system clock, high byte still external
    wr(SRT_ADDR_CLKC, 32'h0000_0020);
    rd(SRT_ADDR_CNTH, 33'h0_0000_0040);
    ext_tick();
    rd(SRT_ADDR_CNTH, 33'h0_0000_0041);
    wrap_up();
  end
endmodule // srt_timer_tb_top
